// ===== hpsh_pkg.sv
package hpsh_pkg;

  // register-select field encodings
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDRESS = 2'h2;
  localparam logic [1:0] SEL_DATA_FIX = 2'h3;

  // control register: bit position of the half-word order flag
  localparam int CTRL_HIGH_FIRST_BIT = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [31:0] ADDR_STEP = 32'h00000004;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [31:0] DATA_RESET = 32'h00000000;

  // select pins sampled together
  typedef struct packed {
    logic [1:0] register_select;
    logic read_write_select;
    logic halfword_select;
  } hpsh_sel_t;

  // request toward the auxiliary DMA channel
  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hpsh_aux_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACCESS = 3'h1,
    ST_WAIT = 3'h3,
    ST_LOAD = 3'h2,
    ST_BUSY = 3'h6
  } hpsh_state_t;

endpackage : hpsh_pkg

// ===== hpsh_host_port.sv
`timescale 1ns/1ps
// Summary of operation
// R1: strobe low when select low, data strobes differ
// R2: ready held low while chip select high
// R3: busy shows ready high at select fall
// R4: first data read half requests DMA word
// R5: ready high until DMA word loaded
// R6: ready high after data write/autoinc read end
// R7: other accesses leave ready low after strobe
// R8: control/address accesses never affect ready
// R9: host holds strobe low until ready low
// R10: drive bus after strobe fall, release after rise
// R11: host holds selects stable around latching edge
// R12: address strobe falls first, else strobe edge
// R13: decode select field, order halves by flag
// R14: synchronise chip select and strobes first
module hpsh_host_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic port_chip_select_n,
  input wire logic data_strobe_one,
  input wire logic data_strobe_two,
  input wire logic address_strobe_n,
  input wire hpsh_pkg::hpsh_sel_t sel_in,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe_n,
  output logic port_ready_n,
  output hpsh_pkg::hpsh_aux_req_t aux_out,
  input wire logic aux_ack,
  input wire logic [31:0] aux_rdata
);
  import hpsh_pkg::*;

  logic [1:0] cs_sync_r, ds1_sync_r, ds2_sync_r, as_sync_r;
  hpsh_sel_t sel_p1_r, sel_p2_r, sel_r;
  logic [15:0] din_p1_r, din_p2_r;
  logic strobe_n_d_r, as_d_r;
  logic cs_n, strobe_n, strobe_fall, strobe_rise, as_fall;
  hpsh_state_t state_r;
  logic [15:0] control_r;
  logic [31:0] addr_r, data_word_r;
  logic inc_pending_r;
  logic is_data, is_second, high_first, high_half;
  logic [15:0] read_half;

  // two-flop synchronisers; first stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sync_r <= 2'h3;
      ds1_sync_r <= 2'h0;
      ds2_sync_r <= 2'h0;
      as_sync_r <= 2'h3;
    end else begin
      cs_sync_r <= {cs_sync_r[0], port_chip_select_n}; // [R14]
      ds1_sync_r <= {ds1_sync_r[0], data_strobe_one}; // [R14]
      ds2_sync_r <= {ds2_sync_r[0], data_strobe_two}; // [R14]
      as_sync_r <= {as_sync_r[0], address_strobe_n}; // [R14]
    end
  end

  // selects and data delayed to line up with the synchronised strobes,
  // since the host holds them only briefly past the latching edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_p1_r <= '0;
      sel_p2_r <= '0;
      din_p1_r <= HALF_RESET;
      din_p2_r <= HALF_RESET;
    end else begin
      sel_p1_r <= sel_in;
      sel_p2_r <= sel_p1_r;
      din_p1_r <= host_data_in;
      din_p2_r <= din_p1_r;
    end
  end

  assign cs_n = cs_sync_r[1];
  assign strobe_n = ~(ds1_sync_r[1] ^ ds2_sync_r[1]) | cs_n; // [R1]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_n_d_r <= 1'b1;
      as_d_r <= 1'b1;
    end else begin
      strobe_n_d_r <= strobe_n;
      as_d_r <= as_sync_r[1];
    end
  end

  assign strobe_fall = strobe_n_d_r & ~strobe_n;
  assign strobe_rise = ~strobe_n_d_r & strobe_n;
  assign as_fall = as_d_r & ~as_sync_r[1];

  // latch selects on address strobe fall, or on strobe fall when it is tied high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_r <= '0;
    end else if (as_fall || (strobe_fall && as_sync_r[1])) begin
      sel_r <= sel_p2_r; // [R12] [R11]
    end
  end

  // the select for this access: fresh one at a strobe-tied-high fall
  hpsh_sel_t cur_sel;
  assign cur_sel = (strobe_fall && as_sync_r[1]) ? sel_p2_r : sel_r;

  assign is_data = cur_sel.register_select == SEL_DATA_INC ||
                   cur_sel.register_select == SEL_DATA_FIX; // [R13]
  assign is_second = cur_sel.halfword_select;
  assign high_first = control_r[CTRL_HIGH_FIRST_BIT];
  assign high_half = high_first ^ is_second; // [R13]

  always_comb begin
    case (cur_sel.register_select)
      SEL_CONTROL: read_half = control_r;
      SEL_ADDRESS: read_half = high_half ? addr_r[31:16] : addr_r[15:0];
      default: read_half = high_half ? data_word_r[31:16] : data_word_r[15:0];
    endcase
  end

  // handshake sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:
          if (strobe_fall) begin
            if (is_data && cur_sel.read_write_select && !is_second) begin
              state_r <= ST_WAIT; // [R4]
            end else begin
              state_r <= ST_ACCESS;
            end
          end
        ST_WAIT:
          if (aux_ack) begin
            state_r <= ST_LOAD; // [R5]
          end
        // one spare cycle so the bus shows the new word before ready falls
        ST_LOAD: state_r <= ST_ACCESS; // [R10]
        ST_ACCESS:
          if (strobe_rise) begin
            if (is_data && is_second &&
                (!cur_sel.read_write_select ||
                 cur_sel.register_select == SEL_DATA_INC)) begin
              state_r <= ST_BUSY; // [R6]
            end else begin
              state_r <= ST_IDLE; // [R7] [R8]
            end
          end
        ST_BUSY:
          if (!aux_out.req && !inc_pending_r) begin
            state_r <= ST_IDLE;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ready: gated by chip select, high while waiting or completing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_ready_n <= 1'b0;
    end else if (cs_n) begin
      port_ready_n <= 1'b0; // [R2]
    end else begin
      port_ready_n <= state_r == ST_WAIT || state_r == ST_LOAD ||
                      state_r == ST_BUSY; // [R3] [R5] [R6]
    end
  end

  // auxiliary DMA requests; held until acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_out <= '0;
    end else if (aux_out.req) begin
      if (aux_ack) begin
        aux_out.req <= 1'b0;
      end
    end else if (state_r == ST_IDLE && strobe_fall && is_data &&
                 cur_sel.read_write_select && !is_second) begin
      aux_out <= '{req: 1'b1, write: 1'b0, addr: addr_r, wdata: data_word_r}; // [R4]
    end else if (state_r == ST_ACCESS && strobe_rise && is_data && is_second &&
                 !cur_sel.read_write_select) begin
      aux_out <= '{req: 1'b1, write: 1'b1, addr: addr_r,
                   wdata: high_half ? {din_p2_r, data_word_r[15:0]} :
                                      {data_word_r[31:16], din_p2_r}}; // [R6]
    end
  end

  // address increment after an auto-increment data access completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inc_pending_r <= 1'b0;
    end else if (state_r == ST_ACCESS && strobe_rise && is_second &&
                 cur_sel.register_select == SEL_DATA_INC) begin
      inc_pending_r <= 1'b1; // [R6]
    end else if (inc_pending_r && !aux_out.req) begin
      inc_pending_r <= 1'b0;
    end
  end

  // control and address halves written at strobe rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_r <= CTRL_RESET;
      addr_r <= ADDR_RESET;
    end else if (inc_pending_r && !aux_out.req) begin
      addr_r <= addr_r + ADDR_STEP;
    end else if (state_r == ST_ACCESS && strobe_rise && !cur_sel.read_write_select) begin
      if (cur_sel.register_select == SEL_CONTROL) begin
        control_r <= din_p2_r; // [R8]
      end else if (cur_sel.register_select == SEL_ADDRESS) begin
        if (high_half) begin
          addr_r[31:16] <= din_p2_r; // [R13]
        end else begin
          addr_r[15:0] <= din_p2_r; // [R13]
        end
      end
    end
  end

  // data word: loaded by DMA, or first write half held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_word_r <= DATA_RESET;
    end else if (state_r == ST_WAIT && aux_ack) begin
      data_word_r <= aux_rdata; // [R5]
    end else if (state_r == ST_ACCESS && strobe_rise && is_data &&
                 !cur_sel.read_write_select) begin
      if (high_half) begin
        data_word_r[31:16] <= din_p2_r;
      end else begin
        data_word_r[15:0] <= din_p2_r;
      end
    end
  end

  // host data bus: driven on reads from strobe fall to strobe rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_data_oe_n <= 1'b1;
      host_data_out <= HALF_RESET;
    end else begin
      host_data_oe_n <= ~(~strobe_n && cur_sel.read_write_select); // [R10]
      host_data_out <= read_half; // [R10]
    end
  end

endmodule : hpsh_host_port

// ===== hpsh_chk_sva.sv
`timescale 1ns/1ps
module hpsh_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic port_chip_select_n,
  input wire logic data_strobe_one,
  input wire logic data_strobe_two,
  input wire hpsh_pkg::hpsh_sel_t sel_in,
  input wire logic host_data_oe_n,
  input wire logic port_ready_n,
  input wire hpsh_pkg::hpsh_aux_req_t aux_out,
  input wire logic aux_ack
);
  import hpsh_pkg::*;
  wire strobe_n = ~(data_strobe_one ^ data_strobe_two) | port_chip_select_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // idle port only: a strobe fall while busy is refused
  sequence s_rd_fall;
    $fell(strobe_n) && !port_ready_n && sel_in.read_write_select &&
      sel_in.register_select[0] && !sel_in.halfword_select;
  endsequence
  sequence s_reg_fall;
    $fell(strobe_n) && !port_ready_n && !sel_in.register_select[0];
  endsequence
  sequence s_rd_wait;
    aux_out.req && !aux_out.write ##1 aux_out.req;
  endsequence
  AST_CS_READY: assert property (port_chip_select_n [*5] |-> !port_ready_n)
    else $error("ready not low while deselected");
  AST_READ_REQ: assert property (s_rd_fall |-> ##[1:6] aux_out.req && !aux_out.write)
    else $error("no read request");
  AST_READ_WAIT: assert property (s_rd_wait |-> port_ready_n)
    else $error("ready before word loaded");
  AST_LOAD_READY: assert property (aux_ack && aux_out.req && !aux_out.write |->
    ##[1:4] !port_ready_n) else $error("ready late after load");
  AST_WRITE_BUSY: assert property ($rose(aux_out.req) && aux_out.write |->
    ##[0:3] port_ready_n) else $error("not busy during write");
  AST_REQ_HOLD: assert property (aux_out.req && !aux_ack |=> aux_out.req && $stable(aux_out))
    else $error("request dropped early");
  AST_REG_NO_BUSY: assert property (s_reg_fall |-> !port_ready_n [*8])
    else $error("register access changed ready");
  AST_BUS_RELEASE: assert property (strobe_n [*6] |-> host_data_oe_n)
    else $error("bus not released");
endmodule : hpsh_chk

bind hpsh_host_port hpsh_chk u_chk (.clk, .rst, .port_chip_select_n, .data_strobe_one,
  .data_strobe_two, .sel_in, .host_data_oe_n, .port_ready_n, .aux_out, .aux_ack);

// ===== hpsh_dma_model.sv
`timescale 1ns/1ps
module hpsh_dma_model (
  input wire logic clk,
  input wire logic rst,
  input wire hpsh_pkg::hpsh_aux_req_t aux_out,
  input wire logic [7:0] lat,
  output logic aux_ack,
  output logic [31:0] aux_rdata
);
  import hpsh_pkg::*;
  logic [31:0] mem [16];
  logic [7:0] cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_ack <= 1'b0;
      cnt_r <= 8'h00;
      aux_rdata <= 32'h00000000;
    end else if (aux_out.req && !aux_ack && cnt_r >= lat) begin
      aux_ack <= 1'b1;
      cnt_r <= 8'h00;
      if (aux_out.write) mem[aux_out.addr[5:2]] <= aux_out.wdata;
      aux_rdata <= mem[aux_out.addr[5:2]];
    end else begin
      aux_ack <= 1'b0;
      cnt_r <= (aux_out.req && !aux_ack) ? cnt_r + 8'h01 : 8'h00;
      // outside the ack cycle the data must not look valid
      aux_rdata <= ~aux_rdata;
    end
  end
endmodule : hpsh_dma_model

// ===== hpsh_tb.sv
`timescale 1ns/1ps
module tb;
  import hpsh_pkg::*;
  logic clk, rst, cs_n, ds1, ds2, as_n, use_as, ack, oe_n, rdy_n;
  // ready level sampled just after the busy window would have opened
  logic busy_after;
  logic [15:0] hdi, hdo, rv;
  logic [31:0] rdata;
  logic [7:0] lat;
  hpsh_sel_t sel;
  hpsh_aux_req_t aux;
  int fail_count = 0;
  int samples_checked = 0;
  hpsh_host_port dut (.clk(clk), .rst(rst), .port_chip_select_n(cs_n),
    .data_strobe_one(ds1), .data_strobe_two(ds2), .address_strobe_n(as_n),
    .sel_in(sel), .host_data_in(hdi), .host_data_out(hdo), .host_data_oe_n(oe_n),
    .port_ready_n(rdy_n), .aux_out(aux), .aux_ack(ack), .aux_rdata(rdata));
  hpsh_dma_model mdl (.clk(clk), .rst(rst), .aux_out(aux), .lat(lat),
    .aux_ack(ack), .aux_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hx(input logic [3:0] s, input logic [15:0] wd, output logic [15:0] r);
    int n;
    n = 0;
    // a strobe fall while busy is dropped, so wait for ready first
    while (rdy_n !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    sel = hpsh_sel_t'(s);
    hdi = wd;
    @(negedge clk);
    as_n = !use_as;
    @(negedge clk);
    if (s[0]) ds2 = 1'b1; else ds1 = 1'b1;
    repeat (4) @(negedge clk);
    while (rdy_n !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    r = hdo;
    if (s[1]) chk(oe_n, 0);
    {ds1, ds2, as_n} = 3'b001;
    // busy shows only some cycles after the strobe rises
    repeat (4) @(negedge clk);
    busy_after = rdy_n;
    repeat (2) @(negedge clk);
    chk(n < 300, 1);
  endtask : hx
  task automatic wr2(input logic [1:0] rs, input logic [31:0] v);
    hx({rs, 2'b00}, v[15:0], rv);
    hx({rs, 2'b01}, v[31:16], rv);
  endtask : wr2
  task automatic rdc(input logic [1:0] rs, input logic hw, input logic [15:0] e);
    hx({rs, 1'b1, hw}, 16'h0000, rv);
    chk(rv, e);
  endtask : rdc
  task automatic t_busy;
    lat = 8'h1E;
    wr2(SEL_ADDRESS, 32'h00000010);
    wr2(SEL_DATA_INC, 32'hABCD1234);
    chk(busy_after, 1);
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(rdy_n, 0);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    chk(rdy_n, 1);
    rdc(SEL_ADDRESS, 0, 16'h0014);
    chk(mdl.mem[4], 32'hABCD1234);
  endtask : t_busy
  task automatic t_read;
    lat = 8'h05;
    use_as = 1'b1;
    wr2(SEL_ADDRESS, 32'h00000010);
    use_as = 1'b0;
    rdc(SEL_DATA_FIX, 0, 16'h1234);
    rdc(SEL_DATA_FIX, 1, 16'hABCD);
    chk(busy_after, 0);
    lat = 8'h00;
    wr2(SEL_CONTROL, 32'h00010001);
    rdc(SEL_CONTROL, 0, 16'h0001);
    chk(busy_after, 0);
    rdc(SEL_DATA_FIX, 0, 16'hABCD);
    rdc(SEL_DATA_FIX, 1, 16'h1234);
    wr2(SEL_CONTROL, 32'h00000000);
    rdc(SEL_DATA_INC, 0, 16'h1234);
    rdc(SEL_DATA_INC, 1, 16'hABCD);
    chk(busy_after, 1);
    rdc(SEL_ADDRESS, 0, 16'h0014);
  endtask : t_read
  // equal data strobes, or a high chip select, must never start an access
  task automatic t_strobe;
    sel = hpsh_sel_t'({SEL_DATA_FIX, 2'b10});
    @(negedge clk);
    {ds1, ds2} = 2'b11;
    repeat (6) @(negedge clk);
    chk({aux.req, rdy_n, oe_n}, 3'b001);
    {ds1, ds2} = 2'b00;
    cs_n = 1'b1;
    @(negedge clk);
    ds1 = 1'b1;
    repeat (6) @(negedge clk);
    chk({aux.req, rdy_n, oe_n}, 3'b001);
    ds1 = 1'b0;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({aux.req, rdy_n, oe_n}, 3'b001);
  endtask : t_strobe
  initial begin
    {rst, cs_n, as_n} = 3'b111;
    {ds1, ds2, use_as} = 3'b000;
    {sel, hdi, lat} = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk({oe_n, rdy_n, aux.req}, 3'b100);
    cs_n = 1'b0;
    t_busy();
    t_read();
    t_strobe();
    results();
  end
  // well over ten times the expected run length
  initial begin
    repeat (8000) @(posedge clk);
    $display("Error %0t watchdog expired", $time);
    fail_count++;
    results();
  end
endmodule : tb
